// file: scmt_pkg.sv
package scmt_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 250_000_000;
	localparam int BAUD_RATE     = 9600;
	localparam int BIT_CYCLES    = CLK_HZ / BAUD_RATE;
	localparam int SYNC_STAGES   = 3;

	// ----------------------------------------------------------------
	// Framing characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CHAR_STX = 8'h02;
	localparam logic [7:0] CHAR_CR  = 8'h0d;
	localparam logic [7:0] CHAR_LF  = 8'h0a;

	// ----------------------------------------------------------------
	// Register map (byte wide, 5-bit address)
	// ----------------------------------------------------------------
	localparam int         IMG_BYTES     = 8;
	localparam logic [4:0] OUT_IMG_BASE  = 5'h00;
	localparam logic [4:0] IN_IMG_BASE   = 5'h08;
	localparam logic [4:0] STATUS_ADDR   = 5'h10;
	localparam logic [7:0] OUT_IMG_RESET = 8'h00;

	// Output image fields
	localparam int CTRL_BYTE    = 0;
	localparam int MODE_BIT     = 0;
	localparam int CMD_BYTE_LO  = 2;
	localparam int CMD_BYTE_HI  = 3;
	localparam int CMD_BITS     = 16;

	// Input image layout for collective mode
	localparam int IN_SEQ       = 0;
	localparam int IN_INFO      = 1;
	localparam int IN_DATA0     = 2;
	localparam int IN_TOTAL     = 6;
	localparam int FRAG_CHARS   = 4;
	localparam int INFO_LAST    = 7;

	// Status register fields
	localparam int ST_RX_ERR    = 1;
	localparam int ST_MODE      = 2;
	localparam int ST_TX_BUSY   = 3;
	localparam int ST_SEL_LSB   = 4;

	// Selector positions served by this block
	localparam logic [3:0] SEL_POS2 = 4'h2;
	localparam logic [3:0] SEL_POS4 = 4'h4;
	localparam logic [3:0] SEL_POS5 = 4'h5;

	// Longest command text in characters
	localparam int CMD_MAX_CHARS = 4;

	typedef enum logic [2:0] {
		TX_IDLE, TX_STX, TX_BODY, TX_CR, TX_LF
	} scmt_tx_state_t;

	typedef enum logic [1:0] {
		RX_HUNT, RX_BODY, RX_LF
	} scmt_rx_state_t;

endpackage

// file: scmt_uart_tx.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// 8N1 transmitter, one byte per handshake
// ------------------------------------------------------------------
module scmt_uart_tx #(
	parameter int BIT_CYCLES = scmt_pkg::BIT_CYCLES
) (
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic       valid_in,
	input  wire logic [7:0] data_in,
	output logic            ready_out,
	output logic            txd_out
);
	initial
	begin
		if (BIT_CYCLES < 4)
			$error("BIT_CYCLES too small");
	end

	logic [31:0] div_q;
	logic [3:0]  bit_q;
	logic [9:0]  shift_q;
	wire         bit_tick = (div_q == 32'(BIT_CYCLES - 1));
	wire         take     = valid_in && ready_out;

	// Start, 8 data LSB first, one stop; no parity
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			div_q     <= 32'h0;
			bit_q     <= 4'h0;
			shift_q   <= 10'h3ff;
			ready_out <= 1'b1;
			txd_out   <= 1'b1;
		end
		else if (take)
		begin
			shift_q   <= {1'b1, data_in, 1'b0};
			bit_q     <= 4'h0;
			div_q     <= 32'h0;
			ready_out <= 1'b0;
			txd_out   <= 1'b0;
		end
		else if (!ready_out)
		begin
			div_q <= bit_tick ? 32'h0 : div_q + 32'h1;
			if (bit_tick)
			begin
				bit_q   <= bit_q + 4'h1;
				shift_q <= {1'b1, shift_q[9:1]};
				txd_out <= (bit_q == 4'h9) ? 1'b1 : shift_q[1];
				ready_out <= (bit_q == 4'h9);
			end
		end
	end
endmodule

// file: scmt_uart_rx.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// 8N1 receiver on an already synchronised line
// ------------------------------------------------------------------
module scmt_uart_rx #(
	parameter int BIT_CYCLES = scmt_pkg::BIT_CYCLES
) (
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic       rxd_in,
	output logic            valid_out,
	output logic [7:0]      data_out,
	output logic            err_out
);
	logic [31:0] div_q;
	logic [3:0]  bit_q;
	logic        busy_q;
	logic [7:0]  shift_q;
	wire         sample = busy_q && (div_q == 32'(BIT_CYCLES - 1));

	// Start found on falling line, first sample half a bit later
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			div_q     <= 32'h0;
			bit_q     <= 4'h0;
			busy_q    <= 1'b0;
			shift_q   <= 8'h00;
			valid_out <= 1'b0;
			data_out  <= 8'h00;
			err_out   <= 1'b0;
		end
		else
		begin
			valid_out <= 1'b0;
			err_out   <= 1'b0;
			if (!busy_q && !rxd_in)
			begin
				busy_q <= 1'b1;
				bit_q  <= 4'h0;
				div_q  <= 32'(BIT_CYCLES / 2);
			end
			else if (busy_q)
			begin
				div_q <= sample ? 32'h0 : div_q + 32'h1;
				if (sample)
				begin
					bit_q <= bit_q + 4'h1;
					if (bit_q == 4'h0 && rxd_in)
						busy_q <= 1'b0; // Glitch, not a start bit
					else if (bit_q == 4'h9)
					begin
						busy_q    <= 1'b0;
						valid_out <= rxd_in;
						err_out   <= !rxd_in; // Missing stop bit
						data_out  <= shift_q;
					end
					else if (bit_q != 4'h0)
						shift_q <= {rxd_in, shift_q[7:1]};
				end
			end
		end
	end
endmodule

// file: scmt_top.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Command-mode translator: output image bits to framed scanner
// commands, framed scanner replies into the input image
// ------------------------------------------------------------------
module scmt_top #(
	parameter int BIT_CYCLES = scmt_pkg::BIT_CYCLES
) (
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic [4:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	input  wire logic [3:0] device_selector_switch_in,
	input  wire logic       scanner_rxd_in,
	output logic            scanner_txd_out,
	output logic            cmd_mode_out
);
	initial
	begin
		if (BIT_CYCLES < 4)
			$error("BIT_CYCLES too small");
	end

	localparam int NP = 5; // Pin count: selector plus receive line

	// ----------------------------------------------------------------
	// Command table
	// ----------------------------------------------------------------
	// Returns {length, text}; text is right aligned, first char highest.
	// A falling edge only has a command for the on/off pairs.
	function automatic logic [34:0] cmd_lookup(input logic [3:0] sel,
		input int bit_idx, input logic rise);
		logic [2:0]  len;
		logic [31:0] txt;
		len = 3'd0;
		txt = 32'h0;
		// Entries common to positions 2 and 4
		if (sel == scmt_pkg::SEL_POS2 || sel == scmt_pkg::SEL_POS4)
		begin
			case (bit_idx)
				4: begin len = 3'd3; txt = rise ? {8'h00, "CA+"}
					: {8'h00, "CA-"}; end
				5: if (rise) begin len = 3'd3; txt = {8'h00, "0A1"}; end
				6: if (rise) begin len = 3'd3; txt = {8'h00, "0A2"}; end
				7: if (rise) begin len = 3'd3; txt = {8'h00, "0D1"}; end
				8: if (rise) begin len = 3'd3; txt = {8'h00, "0D2"}; end
				default: ;
			endcase
		end
		// Position 2 bits 9, 10 and 15 stay empty
		if (sel == scmt_pkg::SEL_POS2)
		begin
			case (bit_idx)
				0: if (rise) begin len = 3'd1; txt = {24'h0, "v"}; end
				1: begin len = 3'd1; txt = rise ? {24'h0, "+"}
					: {24'h0, "-"}; end
				2: if (rise) begin len = 3'd3; txt = {8'h00, "RT1"}; end
				3: if (rise) begin len = 3'd3; txt = {8'h00, "RT2"}; end
				11: if (rise) begin len = 3'd2; txt = {16'h0, "VB"}; end
				12: if (rise) begin len = 3'd2; txt = {16'h0, "VK"}; end
				13: if (rise) begin len = 3'd4; txt = "PC20"; end
				14: if (rise) begin len = 3'd1; txt = {24'h0, "H"}; end
				default: ;
			endcase
		end
		// Position 4 bits 3, 9 to 12 stay empty
		if (sel == scmt_pkg::SEL_POS4)
		begin
			case (bit_idx)
				0: if (rise) begin len = 3'd1; txt = {24'h0, "V"}; end
				1: begin len = 3'd1; txt = rise ? {24'h0, "+"}
					: {24'h0, "-"}; end
				2: begin len = 3'd3; txt = rise ? {8'h00, "RT+"}
					: {8'h00, "RT-"}; end
				13: if (rise) begin len = 3'd4; txt = "PD20"; end
				14: if (rise) begin len = 3'd4; txt = "PC20"; end
				15: if (rise) begin len = 3'd1; txt = {24'h0, "H"}; end
				default: ;
			endcase
		end
		// Position 5 bits 5 to 13 stay empty
		if (sel == scmt_pkg::SEL_POS5)
		begin
			case (bit_idx)
				0: if (rise) begin len = 3'd1; txt = {24'h0, "v"}; end
				1: begin len = 3'd1; txt = rise ? {24'h0, "+"}
					: {24'h0, "-"}; end
				2: if (rise) begin len = 3'd2; txt = {16'h0, "11"}; end
				3: if (rise) begin len = 3'd2; txt = {16'h0, "12"}; end
				4: if (rise) begin len = 3'd2; txt = {16'h0, "13"}; end
				14: if (rise) begin len = 3'd4; txt = "PC20"; end
				15: if (rise) begin len = 3'd1; txt = {24'h0, "H"}; end
				default: ;
			endcase
		end
		return {len, txt};
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers: three stages, change accepted when 2 and 3 agree
	// ----------------------------------------------------------------
	logic [NP-1:0] sync1_q;
	logic [NP-1:0] sync2_q;
	logic [NP-1:0] sync3_q;
	logic [NP-1:0] pin_q;
	logic [NP-1:0] pin_d;
	wire  [NP-1:0] pin_raw = {scanner_rxd_in, device_selector_switch_in};

	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++)
		begin : g_pin
			assign pin_d[gp] = (sync2_q[gp] == sync3_q[gp]) ? sync3_q[gp]
				: pin_q[gp];
		end
	endgenerate

	// Idle line is high, selector starts at position 0 (no table)
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sync1_q <= {1'b1, 4'h0};
			sync2_q <= {1'b1, 4'h0};
			sync3_q <= {1'b1, 4'h0};
			pin_q   <= {1'b1, 4'h0};
		end
		else
		begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= pin_d;
		end
	end

	wire [3:0] sel    = pin_q[3:0];
	wire       rxd    = pin_q[4];

	// ----------------------------------------------------------------
	// Register bus: output image, input image, status
	// ----------------------------------------------------------------
	logic [7:0] out_img_q [scmt_pkg::IMG_BYTES];
	logic [7:0] in_img_q  [scmt_pkg::IMG_BYTES];
	logic [7:0] rdata_d;
	logic       rx_err_q;
	logic       tx_busy;

	wire        hit_out = (addr_in[4:3] == scmt_pkg::OUT_IMG_BASE[4:3]);
	wire        hit_in  = (addr_in[4:3] == scmt_pkg::IN_IMG_BASE[4:3]);
	wire        hit_st  = (addr_in == scmt_pkg::STATUS_ADDR);
	wire [7:0]  status  = {sel, tx_busy, cmd_mode_out, rx_err_q, 1'b0};

	// Unmapped addresses read zero
	assign rdata_d = hit_out ? out_img_q[addr_in[2:0]]
		: hit_in ? in_img_q[addr_in[2:0]]
		: hit_st ? status : 8'h00;

	// Whole 8-byte output image is writable by the master
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (int i = 0; i < scmt_pkg::IMG_BYTES; i++)
				out_img_q[i] <= scmt_pkg::OUT_IMG_RESET;
			rdata_out <= 8'h00;
		end
		else
		begin
			if (wr_in && hit_out)
				out_img_q[addr_in[2:0]] <= wdata_in;
			rdata_out <= rd_in ? rdata_d : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Command bit edges and pending set
	// ----------------------------------------------------------------
	wire        mode_en = out_img_q[scmt_pkg::CTRL_BYTE][scmt_pkg::MODE_BIT];
	wire [15:0] cmd_bits = {out_img_q[scmt_pkg::CMD_BYTE_HI],
		out_img_q[scmt_pkg::CMD_BYTE_LO]};
	logic [15:0] prev_q;
	logic [15:0] rise_pend_q;
	logic [15:0] fall_pend_q;
	logic [15:0] rise_set;
	logic [15:0] fall_set;
	logic [15:0] rise_clr;
	logic [15:0] fall_clr;

	// Edges count only with command mode on and a command present
	genvar gb;
	generate
		for (gb = 0; gb < scmt_pkg::CMD_BITS; gb++)
		begin : g_edge
			wire [34:0] r_ent = cmd_lookup(sel, gb, 1'b1);
			wire [34:0] f_ent = cmd_lookup(sel, gb, 1'b0);
			assign rise_set[gb] = mode_en && cmd_bits[gb] && !prev_q[gb]
				&& (r_ent[34:32] != 3'd0);
			assign fall_set[gb] = mode_en && !cmd_bits[gb] && prev_q[gb]
				&& (f_ent[34:32] != 3'd0);
		end
	endgenerate

	// A new edge wins over the clear of an older one
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			prev_q      <= 16'h0000;
			rise_pend_q <= 16'h0000;
			fall_pend_q <= 16'h0000;
			cmd_mode_out <= 1'b0;
		end
		else
		begin
			prev_q      <= cmd_bits;
			rise_pend_q <= (rise_pend_q & ~rise_clr) | rise_set;
			fall_pend_q <= (fall_pend_q & ~fall_clr) | fall_set;
			cmd_mode_out <= mode_en;
		end
	end

	// ----------------------------------------------------------------
	// Transmit sequencer: lowest bit first, rising before falling
	// ----------------------------------------------------------------
	scmt_pkg::scmt_tx_state_t tx_st_q;
	logic [2:0]  len_q;
	logic [31:0] txt_q;
	logic [2:0]  idx_q;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_ready;
	logic        pick_any;
	logic        pick_rise;
	logic [3:0]  pick_idx;

	always_comb
	begin
		pick_any  = 1'b0;
		pick_rise = 1'b0;
		pick_idx  = 4'h0;
		for (int i = scmt_pkg::CMD_BITS - 1; i >= 0; i--)
		begin
			if (rise_pend_q[i] || fall_pend_q[i])
			begin
				pick_any  = 1'b1;
				pick_rise = rise_pend_q[i];
				pick_idx  = 4'(i);
			end
		end
	end

	wire        start   = (tx_st_q == scmt_pkg::TX_IDLE) && pick_any;
	wire [34:0] pick_e  = cmd_lookup(sel, int'(pick_idx), pick_rise);
	wire        accept  = tx_valid && tx_ready;
	assign rise_clr = (start && pick_rise) ? (16'h1 << pick_idx) : 16'h0;
	assign fall_clr = (start && !pick_rise) ? (16'h1 << pick_idx) : 16'h0;
	assign tx_valid = (tx_st_q != scmt_pkg::TX_IDLE);
	assign tx_busy  = tx_valid || !tx_ready;

	// Frame wraps the command text: STX, text, CR, LF
	always_comb
	begin
		case (tx_st_q)
			scmt_pkg::TX_STX:  tx_data = scmt_pkg::CHAR_STX;
			scmt_pkg::TX_BODY: tx_data = txt_q[(len_q - 3'd1 - idx_q) * 8 +: 8];
			scmt_pkg::TX_CR:   tx_data = scmt_pkg::CHAR_CR;
			scmt_pkg::TX_LF:   tx_data = scmt_pkg::CHAR_LF;
			default:           tx_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			tx_st_q <= scmt_pkg::TX_IDLE;
			len_q   <= 3'd0;
			txt_q   <= 32'h0;
			idx_q   <= 3'd0;
		end
		else
		begin
			case (tx_st_q)
				scmt_pkg::TX_IDLE:
					if (start)
					begin
						len_q   <= pick_e[34:32];
						txt_q   <= pick_e[31:0];
						idx_q   <= 3'd0;
						tx_st_q <= scmt_pkg::TX_STX;
					end
				scmt_pkg::TX_STX:
					if (accept)
						tx_st_q <= scmt_pkg::TX_BODY;
				scmt_pkg::TX_BODY:
					if (accept)
					begin
						idx_q <= idx_q + 3'd1;
						if (idx_q == len_q - 3'd1)
							tx_st_q <= scmt_pkg::TX_CR;
					end
				scmt_pkg::TX_CR:
					if (accept)
						tx_st_q <= scmt_pkg::TX_LF;
				scmt_pkg::TX_LF:
					if (accept)
						tx_st_q <= scmt_pkg::TX_IDLE;
				default:
					tx_st_q <= scmt_pkg::TX_IDLE;
			endcase
		end
	end

	scmt_uart_tx #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_tx (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.valid_in   (tx_valid),
		.data_in    (tx_data),
		.ready_out  (tx_ready),
		.txd_out    (scanner_txd_out)
	);

	// ----------------------------------------------------------------
	// Receive path: strip framing, publish 4-char fragments
	// ----------------------------------------------------------------
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_ferr;

	scmt_uart_rx #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_rx (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.rxd_in     (rxd),
		.valid_out  (rx_valid),
		.data_out   (rx_data),
		.err_out    (rx_ferr)
	);

	scmt_pkg::scmt_rx_state_t rx_st_q;
	logic [7:0] frag_q [scmt_pkg::FRAG_CHARS];
	logic [2:0] frag_cnt_q;
	logic [7:0] total_q;
	wire        is_stx  = (rx_data == scmt_pkg::CHAR_STX);
	wire        is_cr   = (rx_data == scmt_pkg::CHAR_CR);
	wire        is_lf   = (rx_data == scmt_pkg::CHAR_LF);
	wire        body_ch = rx_valid && (rx_st_q == scmt_pkg::RX_BODY)
		&& !is_stx && !is_cr;
	wire        frag_full = body_ch && (frag_cnt_q == 3'(scmt_pkg::FRAG_CHARS - 1));
	wire        frame_end = rx_valid && (rx_st_q == scmt_pkg::RX_LF) && is_lf;

	// Payload bytes are copied as received, never interpreted
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rx_st_q    <= scmt_pkg::RX_HUNT;
			frag_cnt_q <= 3'd0;
			total_q    <= 8'h00;
			rx_err_q   <= 1'b0;
			for (int i = 0; i < scmt_pkg::FRAG_CHARS; i++)
				frag_q[i] <= 8'h00;
		end
		else
		begin
			if (rx_ferr)
				rx_err_q <= 1'b1;
			else if (rd_in && hit_st)
				rx_err_q <= 1'b0; // Status read clears the sticky error
			if (rx_valid)
			begin
				case (rx_st_q)
					scmt_pkg::RX_HUNT:
						if (is_stx)
						begin
							rx_st_q    <= scmt_pkg::RX_BODY;
							frag_cnt_q <= 3'd0;
							total_q    <= 8'h00;
						end
					scmt_pkg::RX_BODY:
						if (is_stx)
						begin
							frag_cnt_q <= 3'd0; // Restart on a fresh STX
							total_q    <= 8'h00;
						end
						else if (is_cr)
							rx_st_q <= scmt_pkg::RX_LF;
						else
						begin
							frag_q[frag_cnt_q[1:0]] <= rx_data;
							frag_cnt_q <= frag_full ? 3'd0 : frag_cnt_q + 3'd1;
							total_q    <= total_q + 8'h01;
						end
					scmt_pkg::RX_LF:
					begin
						rx_st_q <= scmt_pkg::RX_HUNT;
						if (!is_lf)
							rx_err_q <= 1'b1; // CR not followed by LF: drop
					end
					default:
						rx_st_q <= scmt_pkg::RX_HUNT;
				endcase
			end
		end
	end

	// Collective mode: each full fragment or frame end bumps the sequence
	// count; the master must read a fragment before the next one lands.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (int i = 0; i < scmt_pkg::IMG_BYTES; i++)
				in_img_q[i] <= 8'h00;
		end
		else if (frag_full || frame_end)
		begin
			in_img_q[scmt_pkg::IN_SEQ] <= in_img_q[scmt_pkg::IN_SEQ] + 8'h01;
			in_img_q[scmt_pkg::IN_INFO] <= {frame_end, 4'h0,
				frag_full ? 3'(scmt_pkg::FRAG_CHARS) : frag_cnt_q};
			in_img_q[scmt_pkg::IN_TOTAL] <= frag_full ? total_q + 8'h01
				: total_q;
			for (int i = 0; i < scmt_pkg::FRAG_CHARS; i++)
				in_img_q[scmt_pkg::IN_DATA0 + i] <=
					(frag_full && i == scmt_pkg::FRAG_CHARS - 1) ? rx_data
					: (frag_full || 3'(i) < frag_cnt_q) ? frag_q[i] : 8'h00;
		end
	end
endmodule

// file: scmt_props.sv
`timescale 1ns/1ns
// ------------------------
// Port checks
// ------------------------
module scmt_props #(
	parameter int BIT_CYCLES = scmt_pkg::BIT_CYCLES
) (
	input wire logic       clk_sys_in,
	input wire logic       resetn_in,
	input wire logic [4:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       scanner_txd_out,
	input wire logic       cmd_mode_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	logic        prev_q;
	logic [31:0] run_q;
	logic [31:0] run_d;
	// Run length of the line level; low runs must be whole bits.
	// Wide enough for a full low character at the default bit time.
	assign run_d = (scanner_txd_out != prev_q) ? 32'h1 : run_q + 32'h1;
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			prev_q <= 1'b1;
			run_q  <= 32'h0;
		end
		else
		begin
			prev_q <= scanner_txd_out;
			run_q  <= run_d;
		end
	end
	// Bus answers
	property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without read");
	property p_unmap; rd_in && addr_in > 5'h10 |=> rdata_out == 8'h00; endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_readback;
		logic [7:0] v;
		(wr_in && addr_in == 5'h01, v = wdata_in) ##1 !wr_in
			##1 (rd_in && addr_in == 5'h01) |=> rdata_out == v;
	endproperty
	a_readback: assert property (p_readback)
		else $error("output image readback");
	// Command mode follows byte 0 bit 0, two edges after the write:
	// one edge lands the image byte, the next registers the output
	property p_mode_set;
		wr_in && addr_in == 5'h00
			|-> ##2 cmd_mode_out == $past(wdata_in[0], 2);
	endproperty
	a_mode_set: assert property (p_mode_set)
		else $error("mode not taken");
	property p_mode_hold;
		!(wr_in && addr_in == 5'h00) ##1 !(wr_in && addr_in == 5'h00)
			|=> $stable(cmd_mode_out);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed");
	property p_status;
		rd_in && addr_in == 5'h10 |=> rdata_out[2] == $past(cmd_mode_out)
			&& !rdata_out[0];
	endproperty
	a_status: assert property (p_status)
		else $error("status mode bit");
	// Serial line
	property p_rst;
		$rose(resetn_in) |-> scanner_txd_out && !cmd_mode_out;
	endproperty
	a_rst: assert property (p_rst)
		else $error("line not idle after reset");
	property p_bit; $rose(scanner_txd_out) |-> run_q % BIT_CYCLES == 0; endproperty
	a_bit: assert property (p_bit)
		else $error("bit time");
endmodule

bind scmt_top scmt_props #(.BIT_CYCLES(BIT_CYCLES)) u_scmt_props (
	.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .scanner_txd_out(scanner_txd_out),
	.cmd_mode_out(cmd_mode_out));

// file: scmt_scan.sv
`timescale 1ns/1ns
// ------------------------
// Scanner at the far end
// ------------------------
module scmt_scan #(
	parameter int BIT = 16
) (
	input  wire logic clk_in,
	input  wire logic txd_in,
	output logic      rxd_out
);
	logic [7:0] rx_q [$];
	logic [7:0] b;
	initial rxd_out = 1'b1;
	// Sample mid bit, LSB first; nothing is acknowledged
	always
	begin
		@(negedge txd_in);
		repeat (BIT / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk_in);
			b[i] = txd_in;
		end
		repeat (BIT) @(posedge clk_in);
		rx_q.push_back(b);
	end
	// Framed reply; gap idles between characters for a slow scanner
	task automatic send(input string s, input int gap);
		logic [7:0] c;
		logic [9:0] f;
		for (int k = -1; k <= s.len() + 1; k++)
		begin
			c = k < 0 ? 8'h02 : k == s.len() ? 8'h0d : 8'h0a;
			if (k >= 0 && k < s.len())
				c = s[k];
			f = {1'b1, c, 1'b0};
			for (int j = 0; j < 10; j++)
			begin
				rxd_out <= f[j];
				repeat (BIT) @(posedge clk_in);
			end
			repeat (gap) @(posedge clk_in);
		end
	endtask
endmodule

// file: scmt_bench.sv
`timescale 1ns/1ns
module scmt_bench;
	localparam int BIT = 16;
	logic       clk_sys_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic [4:0] addr_in = 5'h00;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in = 1'b0;
	logic       rd_in = 1'b0;
	logic [7:0] rdata_out;
	logic [3:0] sel = 4'h0;
	logic       rxd;
	logic       txd;
	logic       mode;
	int         n_errors = 0;
	int         compares = 0;
	logic [7:0] img [8] = '{8'h02, 8'h82, "E", "F", 8'h00, 8'h00, 8'h06, 8'h00};
	string      t2 [16] = '{"v", "+", "RT1", "RT2", "CA+", "0A1", "0A2",
		"0D1", "0D2", "", "", "VB", "VK", "PC20", "H", ""};
	string      t4 [16] = '{"V", "+", "RT+", "", "CA+", "0A1", "0A2",
		"0D1", "0D2", "", "", "", "", "PD20", "PC20", "H"};
	string      t5 [16] = '{"v", "+", "11", "12", "13", "", "", "",
		"", "", "", "", "", "", "PC20", "H"};
	string      e;
	logic [15:0] m;
	always #2 clk_sys_in = ~clk_sys_in;
	scmt_top #(.BIT_CYCLES(BIT)) u_scmt_top (.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.device_selector_switch_in(sel), .scanner_rxd_in(rxd),
		.scanner_txd_out(txd), .cmd_mode_out(mode));
	scmt_scan #(.BIT(BIT)) u_scmt_scan (.clk_in(clk_sys_in), .txd_in(txd),
		.rxd_out(rxd));
	// ------------------------
	// Bus and compare tasks
	// ------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Ends one edge later so a following strobe is a fresh assignment
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		cyc(1);
		wr_in <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		rd_in <= 1'b1;
		addr_in <= a;
		cyc(1);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		chk(rdata_out, exp);
		cyc(1);
	endtask
	// Quiet wait catches both missing and repeated characters
	task automatic expect_frame(input string s);
		int n;
		n = s.len() == 0 ? 0 : s.len() + 3;
		for (int w = 0; w < 100 * BIT && u_scmt_scan.rx_q.size() < n; w++)
			cyc(1);
		cyc(12 * BIT);
		chk(8'(u_scmt_scan.rx_q.size()), 8'(n));
		for (int k = 0; k < n && k < u_scmt_scan.rx_q.size(); k++)
			chk(u_scmt_scan.rx_q[k], k == 0 ? 8'h02 : k == n - 2 ? 8'h0d
				: k == n - 1 ? 8'h0a : s[k - 1]);
		u_scmt_scan.rx_q.delete();
	endtask
	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		cyc(90000);
		n_errors++;
		end_sim;
	end
	// ------------------------
	// Test sequence
	// ------------------------
	initial
	begin
		cyc(16);
		resetn_in <= 1'b1;
		cyc(8);
		for (int i = 0; i < 8; i++)
			rd(5'(i), 8'h00);
		rd(5'h10, 8'h00);
		rd(5'h1f, 8'h00);
		wr(5'h01, 8'ha5);
		rd(5'h01, 8'ha5);
		wr(5'h09, 8'h5a);
		rd(5'h09, 8'h00);
		// Command bit with mode off must stay silent
		sel <= 4'h2;
		cyc(8);
		wr(5'h02, 8'h04);
		expect_frame("");
		wr(5'h02, 8'h00);
		wr(5'h00, 8'h01);
		// Every bit, rise then fall, on selectors 2 to 5; 3 is unsupported
		for (int si = 2; si <= 5; si++)
		begin
			sel <= 4'(si);
			cyc(8);
			for (int b = 0; b < 16; b++)
			begin
				m = 16'h0001 << b;
				e = si == 2 ? t2[b] : si == 4 ? t4[b] : si == 5 ? t5[b] : "";
				wr(b < 8 ? 5'h02 : 5'h03, b < 8 ? m[7:0] : m[15:8]);
				expect_frame(e);
				e = si == 3 ? "" : b == 1 ? "-" : "";
				if (si != 3 && (b == 4 && si != 5 || b == 2 && si == 4))
					e = b == 4 ? "CA-" : "RT-";
				wr(b < 8 ? 5'h02 : 5'h03, 8'h00);
				expect_frame(e);
			end
		end
		// Six-character reply arrives as two fragments
		u_scmt_scan.send("ABCDEF", 20);
		cyc(2 * BIT);
		for (int i = 0; i < 8; i++)
			rd(5'h08 + 5'(i), img[i]);
		rd(5'h10, 8'h54);
		end_sim;
	end
endmodule
